// *** verilog/processor_mode_status_reg.sv ***
// processor mode control register with AXI4-Lite access and its decoders
// assumes core strobes on aclk; the mode pin is asynchronous
//
// Chosen here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module processor_mode_status_reg (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite slave
  input  wire logic [3:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic      [1:0]  bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [3:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic      [31:0] rdata,
  output logic      [1:0]  rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // core side
  input  wire logic        rom_mode_pin,
  input  wire logic        soft_reset,
  input  wire logic [4:0]  vector_num,
  input  wire logic [15:0] prog_addr,
  input  wire logic [15:0] data_addr,
  input  wire logic        ext_access,
  input  wire logic [15:0] ext_addr_in,
  output logic      [15:0] vector_addr,
  output logic             prog_rom_hit,
  output logic             prog_ram_hit,
  output logic             data_rom_hit,
  output logic      [15:0] ext_addr,
  output logic             clock_output_pin,
  input  wire logic        overflow_mode,
  input  wire logic        fractional_mode,
  input  wire logic [31:0] product_in,
  input  wire logic [39:0] acc_in,
  input  wire logic [3:0]  store_shift,
  output logic      [31:0] product_out,
  output logic      [31:0] store_out
);
  import pmode_pkg::*;

  logic [8:0]  vector_page_pointer;  // vector page
  logic        rom_mode_select;      // 1 = on-chip rom off
  logic [5:0]  low_bits;             // overlay .. store saturation
  logic        pin_meta;             // first sync stage, read only by pin_sync
  logic        pin_sync;             // synchronised mode pin
  wr_state_e   wr_state;             // write path state
  logic        aw_got;               // address taken this write
  logic        w_got;                // data taken this write
  logic [3:0]  aw_addr;              // held write address
  logic [31:0] w_data;               // held write data
  logic [3:0]  w_strb;               // held byte enables
  logic        wr_fire;              // write commits this cycle
  logic        wr_hit;               // commit hits the register
  logic [15:0] pmc;                  // register image
  logic        ram_overlay;
  logic        address_visibility;
  logic        data_rom_map;
  logic        clock_output_disable;
  logic        multiply_saturation;
  logic        store_saturation;

  // in-range test shared by the decoders
  function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range

  assign pmc = {vector_page_pointer, rom_mode_select, low_bits};
  assign ram_overlay          = low_bits[OVERLAY_BIT];
  assign address_visibility   = low_bits[VISIBLE_BIT];
  assign data_rom_map         = low_bits[DATA_ROM_BIT];
  assign clock_output_disable = low_bits[CLK_GATE_BIT];
  assign multiply_saturation  = low_bits[MUL_SAT_BIT];
  assign store_saturation     = low_bits[STORE_SAT_BIT];

  // mode pin sync, free running so the value is ready while reset is held
  always_ff @(posedge aclk) begin
    pin_meta <= rom_mode_pin;
    pin_sync <= pin_meta;
  end

  // write path: address and data in either order, then one response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state <= WR_IDLE;
      aw_got   <= 1'b0;
      w_got    <= 1'b0;
    end else begin
      case (wr_state)
        WR_IDLE, WR_PART: begin
          if (wr_fire) begin
            wr_state <= WR_RESP;
            aw_got   <= 1'b0;
            w_got    <= 1'b0;
          end else begin
            if (awvalid && awready) aw_got <= 1'b1;
            if (wvalid && wready) w_got <= 1'b1;
            if ((awvalid && awready) || (wvalid && wready)) wr_state <= WR_PART;
          end
        end
        WR_RESP: begin
          if (bready) wr_state <= WR_IDLE;
        end
        default: wr_state <= WR_IDLE;
      endcase
    end
  end

  // held payload of the write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr <= 4'h0;
      w_data  <= 32'h0;
      w_strb  <= 4'h0;
    end else begin
      if (awvalid && awready) aw_addr <= awaddr;
      if (wvalid && wready) begin
        w_data <= wdata;
        w_strb <= wstrb;
      end
    end
  end

  assign awready = (wr_state != WR_RESP) && !aw_got;
  assign wready  = (wr_state != WR_RESP) && !w_got;
  assign bvalid  = (wr_state == WR_RESP);
  // commit once both halves are present, held or arriving
  assign wr_fire = (wr_state != WR_RESP) && (aw_got || awvalid) && (w_got || wvalid);
  assign wr_hit  = wr_fire && ((aw_got ? aw_addr : awaddr) == PMC_OFFSET);

  // response code: unmapped words answer slave error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bresp <= RESP_OKAY;
    end else if (wr_fire) begin
      bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // vector page pointer: hardware reset only, soft reset leaves it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vector_page_pointer <= PTR_RESET;
    end else if (wr_hit) begin
      if ((w_got ? w_strb[0] : wstrb[0]))
        vector_page_pointer[0] <= (w_got ? w_data[PTR_LSB] : wdata[PTR_LSB]);
      if ((w_got ? w_strb[1] : wstrb[1]))
        vector_page_pointer[8:1] <= (w_got ? w_data[15:8] : wdata[15:8]);
    end
  end

  // rom select follows the pin during reset, then only software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rom_mode_select <= pin_sync;
    end else if (wr_hit && (w_got ? w_strb[0] : wstrb[0])) begin
      rom_mode_select <= (w_got ? w_data[ROM_SEL_BIT] : wdata[ROM_SEL_BIT]);
    end
  end

  // low control bits; soft reset clears them, a bus write the same cycle wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_bits <= LOW_RESET;
    end else if (wr_hit && (w_got ? w_strb[0] : wstrb[0])) begin
      low_bits <= (w_got ? w_data[5:0] : wdata[5:0]);
    end else if (soft_reset) begin
      low_bits <= LOW_RESET;
    end
  end

  // read path: one read in flight, answer one cycle after the address
  assign arready = !rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0;
      rresp  <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata  <= (araddr == PMC_OFFSET) ? {16'h0, pmc} : 32'h0;
      rresp  <= (araddr == PMC_OFFSET) ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // vector fetch address: four words per vector within the page
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vector_addr <= 16'h0;
    end else begin
      vector_addr <= {vector_page_pointer, vector_num, 2'b00};
    end
  end

  // memory decoders, registered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prog_rom_hit <= 1'b0;
      prog_ram_hit <= 1'b0;
      data_rom_hit <= 1'b0;
    end else begin
      prog_rom_hit <= !rom_mode_select && (prog_addr >= PROM_LO);
      // page 0 never overlays program space
      prog_ram_hit <= ram_overlay && in_range(prog_addr, DARAM_LO, DARAM_HI);
      // data rom window is a guess at the portion, kept small
      data_rom_hit <= data_rom_map && in_range(data_addr, DATA_ROM_LO, DATA_ROM_HI);
    end
  end

  // external address pins: trace program address, else take ext_addr_in on an external access, else hold the last
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_addr <= 16'h0;
    end else if (address_visibility) begin
      ext_addr <= prog_addr;
    end else if (ext_access) begin
      ext_addr <= ext_addr_in;
    end
  end

  clock_out_gen u_clk (
    .aclk                 (aclk),
    .aresetn              (aresetn),
    .clock_output_disable (clock_output_disable),
    .clock_output_pin     (clock_output_pin)
  );

  saturation_unit u_sat (
    .aclk                (aclk),
    .aresetn             (aresetn),
    .multiply_saturation (multiply_saturation),
    .store_saturation    (store_saturation),
    .overflow_mode       (overflow_mode),
    .fractional_mode     (fractional_mode),
    .product_in          (product_in),
    .acc_in              (acc_in),
    .store_shift         (store_shift),
    .product_out         (product_out),
    .store_out           (store_out)
  );

  reset_pointer_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(!aresetn) |-> vector_page_pointer == PTR_RESET) else $error("pointer not all ones");
  soft_keeps_ptr_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (soft_reset && !wr_hit) |=> $stable(vector_page_pointer)) else $error("pointer moved");
  soft_keeps_rom_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (soft_reset && !wr_hit) |=> $stable(rom_mode_select)) else $error("rom select moved");
  vector_page_a: assert property (@(posedge aclk) disable iff (!aresetn)
    1 |=> vector_addr == {$past(vector_page_pointer), $past(vector_num), 2'b00})
    else $error("vector address wrong");
  overlay_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (!ram_overlay ##1 !$past(wr_hit)) |-> !prog_ram_hit) else $error("ram in program space");
  page_zero_out_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (prog_addr < DARAM_LO) |=> !prog_ram_hit) else $error("page 0 overlaid");
  rom_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rom_mode_select |=> !prog_rom_hit) else $error("rom mapped while disabled");
  data_rom_map_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !data_rom_map |=> !data_rom_hit) else $error("rom in data space");
  addr_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (!address_visibility && !ext_access) |=> $stable(ext_addr)) else $error("address moved");
  addr_trace_a: assert property (@(posedge aclk) disable iff (!aresetn)
    address_visibility |=> ext_addr == $past(prog_addr)) else $error("address not traced");
  // reset loads: rom select from the synced pin, low bits cleared
  pin_load_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(!aresetn) |-> rom_mode_select == $past(pin_sync))
    else $error("rom select not from pin");
  low_reset_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(!aresetn) |-> low_bits == LOW_RESET) else $error("low bits not cleared");
  // read-back shows the image as it stood when the address was taken
  read_value_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (arvalid && arready && araddr == PMC_OFFSET) |=> rdata == {16'h0, $past(pmc)})
    else $error("read value wrong");
  rom_map_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (!rom_mode_select && prog_addr >= PROM_LO) |=> prog_rom_hit) else $error("rom not mapped");
  cov_write: cover property (@(posedge aclk) disable iff (!aresetn) wr_hit ##1 bvalid);
  cov_read: cover property (@(posedge aclk) disable iff (!aresetn) rvalid && rready);
  cov_overlay: cover property (@(posedge aclk) disable iff (!aresetn) prog_ram_hit);
endmodule : processor_mode_status_reg

// *** verilog/pmode_pkg.sv ***
// constants for the processor mode control register and its decoders
// assumes a 32-bit AXI4-Lite slave port and one 100 MHz clock
package pmode_pkg;
  // bus map
  localparam logic [3:0]  PMC_OFFSET    = 4'h0;   // processor_mode_control word
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  // field positions
  localparam int          PTR_LSB       = 7;
  localparam int          ROM_SEL_BIT   = 6;
  localparam int          OVERLAY_BIT   = 5;
  localparam int          VISIBLE_BIT   = 4;
  localparam int          DATA_ROM_BIT  = 3;
  localparam int          CLK_GATE_BIT  = 2;
  localparam int          MUL_SAT_BIT   = 1;
  localparam int          STORE_SAT_BIT = 0;
  // reset values
  localparam logic [8:0]  PTR_RESET     = 9'h1FF;
  localparam logic [5:0]  LOW_RESET     = 6'h00;
  // memory windows
  localparam logic [15:0] DARAM_LO      = 16'h0080;
  localparam logic [15:0] DARAM_HI      = 16'h9FFF;
  localparam logic [15:0] PROM_LO       = 16'hC000;
  localparam logic [15:0] DATA_ROM_LO   = 16'hF000;
  localparam logic [15:0] DATA_ROM_HI   = 16'hFEFF;
  // clock output: half period in ns, cycles derived at 10 ns
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          PIN_HALF_NS   = 20;
  localparam int          PIN_HALF_CYC  = (PIN_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // saturation limits
  localparam logic [31:0] SAT_POS       = 32'h7FFFFFFF;
  localparam logic [31:0] SAT_NEG       = 32'h80000000;
  // interface states of the write path
  typedef enum logic [2:0] {
    WR_IDLE = 3'b001,
    WR_PART = 3'b010,
    WR_RESP = 3'b100
  } wr_state_e;
endpackage : pmode_pkg

// *** verilog/clock_out_gen.sv ***
// clock output pin generator, gated high by the disable bit
// assumes the same clock as the register block
`timescale 1ns/1ps
module clock_out_gen (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic clock_output_disable,
  output logic      clock_output_pin
);
  import pmode_pkg::*;
  logic [3:0] half_cnt;  // cycles within a half period

  // divider: one-cycle enable at each half period end
  always_ff @(posedge aclk) begin
    if (!aresetn || half_cnt == 4'(PIN_HALF_CYC - 1)) begin
      half_cnt <= 4'h0;
    end else begin
      half_cnt <= half_cnt + 4'h1;
    end
  end

  // pin toggles on the enable; disabled pin parks high
  always_ff @(posedge aclk) begin
    if (!aresetn || clock_output_disable) begin
      clock_output_pin <= 1'b1;
    end else if (half_cnt == 4'(PIN_HALF_CYC - 1)) begin
      clock_output_pin <= ~clock_output_pin;
    end
  end

  park_high_a: assert property (@(posedge aclk) disable iff (!aresetn)
    clock_output_disable |=> clock_output_pin) else $error("clock pin not parked high");
  cov_toggle: cover property (@(posedge aclk) disable iff (!aresetn)
    !clock_output_disable ##1 $fell(clock_output_pin));
endmodule : clock_out_gen

// *** verilog/saturation_unit.sv ***
// product and store saturation, registered results
// assumes fractional products already shifted left by one
`timescale 1ns/1ps
module saturation_unit (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        multiply_saturation,
  input  wire logic        store_saturation,
  input  wire logic        overflow_mode,
  input  wire logic        fractional_mode,
  input  wire logic [31:0] product_in,
  input  wire logic [39:0] acc_in,
  input  wire logic [3:0]  store_shift,
  output logic      [31:0] product_out,
  output logic      [31:0] store_out
);
  import pmode_pkg::*;
  logic [39:0] shifted;  // accumulator after the store shift
  logic        fits;     // shifted value fits 32 signed bits

  always_comb begin
    shifted = acc_in << store_shift;
    fits    = (shifted[39:31] == {9{shifted[31]}});
  end

  // only -1 x -1 in fractional mode overflows the product
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      product_out <= 32'h0;
    end else if (multiply_saturation && overflow_mode && fractional_mode
                 && product_in == SAT_NEG) begin
      product_out <= SAT_POS;
    end else begin
      product_out <= product_in;
    end
  end

  // saturation applies after the shift
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      store_out <= 32'h0;
    end else if (store_saturation && !fits) begin
      store_out <= shifted[39] ? SAT_NEG : SAT_POS;
    end else begin
      store_out <= shifted[31:0];
    end
  end

  mul_sat_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (multiply_saturation && overflow_mode && fractional_mode && product_in == SAT_NEG)
    |=> product_out == SAT_POS) else $error("product not saturated");
  store_sat_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (store_saturation && !fits && !shifted[39]) |=> store_out == SAT_POS)
    else $error("store not saturated");
  cov_store_sat: cover property (@(posedge aclk) disable iff (!aresetn)
    store_saturation && !fits);
endmodule : saturation_unit

// *** bench/processor_mode_status_reg_test.sv ***
// self-checking bench for the processor mode control register block
// assumes the design and pmode_pkg are compiled first; one 100 MHz clock
`timescale 1ns/1ps
module processor_mode_status_reg_test;
  import pmode_pkg::*;
  logic        aclk, aresetn;                       // clock, sync reset (low)
  logic [3:0]  awaddr, araddr, wstrb, store_shift;  // bus addresses, strobes
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, product_in, product_out, store_out;
  logic [1:0]  bresp, rresp;
  logic        rom_mode_pin, soft_reset, ext_access, overflow_mode, fractional_mode;
  logic [4:0]  vector_num;
  logic [15:0] prog_addr, data_addr, ext_addr_in, vector_addr, ext_addr;
  logic        prog_rom_hit, prog_ram_hit, data_rom_hit, clock_output_pin;
  logic [39:0] acc_in;
  logic [1:0]  bq[$];       // notes of expected write responses
  logic [33:0] rq[$];       // notes of expected {rdata, rresp}
  logic [33:0] exp_r;       // note taken by the watcher
  logic [15:0] model;       // bench copy of the register
  integer      mismatches, checks, seed, i, k;
  logic        saw_low;
  // decoder table: {register, prog addr, data addr, {rom, ram, data rom} hits}
  localparam logic [50:0] HIT_TAB [6] = '{
    {16'hFF80, 16'hC000, 16'hF000, 3'b100}, {16'hFFC0, 16'hC000, 16'hF000, 3'b000},
    {16'hFFA8, 16'h0080, 16'hF000, 3'b011}, {16'hFFA8, 16'h007F, 16'hFF00, 3'b000},
    {16'hFF80, 16'h0080, 16'hFEFF, 3'b000}, {16'hFF88, 16'hBFFF, 16'hFEFF, 3'b001}};
  // store table: {acc, shift, saturated result, plain result}
  localparam logic [107:0] ST_TAB [4] = '{
    {40'h0000400000, 4'h8, 32'h40000000, 32'h40000000},
    {40'h0000400000, 4'h9, 32'h7FFFFFFF, 32'h80000000},
    {40'hFFFFC00000, 4'h9, 32'h80000000, 32'h80000000},
    {40'hFFFFC00000, 4'hA, 32'h80000000, 32'h00000000}};

  processor_mode_status_reg i_dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .rom_mode_pin(rom_mode_pin), .soft_reset(soft_reset), .vector_num(vector_num),
    .prog_addr(prog_addr), .data_addr(data_addr), .ext_access(ext_access),
    .ext_addr_in(ext_addr_in), .vector_addr(vector_addr), .prog_rom_hit(prog_rom_hit),
    .prog_ram_hit(prog_ram_hit), .data_rom_hit(data_rom_hit), .ext_addr(ext_addr),
    .clock_output_pin(clock_output_pin), .overflow_mode(overflow_mode),
    .fractional_mode(fractional_mode), .product_in(product_in), .acc_in(acc_in),
    .store_shift(store_shift), .product_out(product_out), .store_out(store_out));

  // free-running 10 ns clock
  always #5 aclk = ~aclk;

  // one comparison; case inequality so an unknown never matches
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // verdict in one place for the normal end and the watchdog
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : print_verdict

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc

  // bus write: address and data offered together, each released when taken
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
                        input logic [1:0] r);
    logic aw_done, w_done;
    aw_done = 0;
    w_done  = 0;
    bq.push_back(r);
    awaddr <= a; wdata <= d; wstrb <= s; awvalid <= 1; wvalid <= 1; bready <= 1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (awvalid && awready) begin aw_done = 1; awvalid <= 0; end
      if (wvalid && wready) begin w_done = 1; wvalid <= 0; end
    end
    do @(posedge aclk); while (!bvalid);
    bready <= 0;
    // idle edge so a following call never reassigns bready in this step
    @(posedge aclk);
  endtask : axi_wr

  // bus read: the expected answer is noted before the request goes out
  task automatic axi_rd(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    rq.push_back({d, r});
    araddr <= a; arvalid <= 1; rready <= 1;
    do @(posedge aclk); while (!arready);
    arvalid <= 0;
    do @(posedge aclk); while (!rvalid);
    rready <= 0;
    // idle edge so a following call never reassigns rready in this step
    @(posedge aclk);
  endtask : axi_rd

  // full write of the register, tracked in the bench copy
  task automatic set_reg(input logic [15:0] d);
    model = d;
    axi_wr(PMC_OFFSET, {16'h0, d}, 4'hF, RESP_OKAY);
  endtask : set_reg

  // hardware reset, 4 cycles low, two idle edges after release
  task automatic hw_reset();
    aresetn <= 0;
    cyc(4);
    aresetn <= 1;
    cyc(2);
  endtask : hw_reset

  // watcher: each bus answer is matched with the oldest note
  always @(posedge aclk) begin
    if (bvalid && bready) check(32'(bresp), 32'(bq.pop_front()));
    if (rvalid && rready) begin
      exp_r = rq.pop_front();
      check(rdata, exp_r[33:2]);
      check(32'(rresp), 32'(exp_r[1:0]));
    end
  end

  // watchdog well past the expected run length
  initial begin
    cyc(20000);
    mismatches++;
    $display("Error at %0t: run did not finish", $time);
    print_verdict();
  end

  // main sequence
  initial begin
    aclk = 0; awaddr = 0; araddr = 0; wstrb = 0; wdata = 0;
    awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
    rom_mode_pin = 1; soft_reset = 0; ext_access = 0; ext_addr_in = 0;
    overflow_mode = 0; fractional_mode = 0; product_in = 0; acc_in = 0; store_shift = 0;
    vector_num = 0; prog_addr = 0; data_addr = 0;
    mismatches = 0; checks = 0; seed = 32'h13db;
    hw_reset();
    // reset value: pointer all ones, mode bit from the pin, rest zero
    axi_rd(PMC_OFFSET, 32'h0000FFC0, RESP_OKAY);
    check(32'(vector_addr), 32'h0000FF80);
    // pin moves without reset: bit keeps its sampled level
    rom_mode_pin <= 0;
    cyc(4);
    axi_rd(PMC_OFFSET, 32'h0000FFC0, RESP_OKAY);
    // random pointers and vector numbers, boundary numbers included
    for (i = 0; i < 4; i++) begin
      set_reg(16'($random(seed)));
      vector_num <= (i == 0) ? 5'd0 : (i == 1) ? 5'd31 : 5'($random(seed));
      cyc(2);
      check(32'(vector_addr), {16'h0, model[15:7], vector_num, 2'b00});
      axi_rd(PMC_OFFSET, {16'h0, model}, RESP_OKAY);
    end
    // upper byte strobe only, then unmapped places refused
    axi_wr(PMC_OFFSET, 32'h0, 4'b0010, RESP_OKAY);
    model[15:8] = 8'h00;
    axi_wr(4'h4, 32'hFFFF, 4'hF, RESP_SLVERR);
    axi_rd(4'h8, 32'h0, RESP_SLVERR);
    axi_rd(PMC_OFFSET, {16'h0, model}, RESP_OKAY);
    // soft reset keeps pointer and mode bit, clears the low six
    set_reg(16'hB5FF);
    soft_reset <= 1;
    cyc(1);
    soft_reset <= 0;
    cyc(1);
    axi_rd(PMC_OFFSET, 32'h0000B5C0, RESP_OKAY);
    // address decoders from the table
    for (i = 0; i < 6; i++) begin
      set_reg(HIT_TAB[i][50:35]);
      prog_addr <= HIT_TAB[i][34:19];
      data_addr <= HIT_TAB[i][18:3];
      cyc(2);
      check(32'(prog_rom_hit), 32'(HIT_TAB[i][2]));
      check(32'(prog_ram_hit), 32'(HIT_TAB[i][1]));
      check(32'(data_rom_hit), 32'(HIT_TAB[i][0]));
    end
    // address visibility on: pins follow the program address
    set_reg(16'hFF90);
    prog_addr <= 16'h1234;
    cyc(2);
    check(32'(ext_addr), 32'h1234);
    // visibility off: pins hold the last external address
    set_reg(16'hFF80);
    ext_access <= 1;
    ext_addr_in <= 16'hA5A5;
    cyc(1);
    ext_access <= 0;
    ext_addr_in <= 16'h5A5A;
    prog_addr <= 16'h4321;
    cyc(4);
    check(32'(ext_addr), 32'hA5A5);
    // clock output held high while disabled, toggles again when enabled
    set_reg(16'hFF84);
    cyc(2);
    for (i = 0; i < 8; i++) begin
      cyc(1);
      check(32'(clock_output_pin), 32'h1);
    end
    set_reg(16'hFF80);
    saw_low = 0;
    for (i = 0; i < 6; i++) begin
      cyc(1);
      if (clock_output_pin === 1'b0) saw_low = 1;
    end
    check(32'(saw_low), 32'h1);
    // product saturation only with all three enables
    for (i = 0; i < 8; i++) begin
      set_reg({14'h3FE0, i[2], 1'b0});
      overflow_mode <= i[1];
      fractional_mode <= i[0];
      product_in <= SAT_NEG;
      cyc(2);
      check(product_out, (i == 7) ? SAT_POS : SAT_NEG);
      product_in <= 32'($random(seed)) | 32'h1;
      cyc(2);
      check(product_out, product_in);
    end
    // store saturation after the shift
    for (k = 0; k < 2; k++) begin
      set_reg({15'h7FC0, k[0]});
      for (i = 0; i < 4; i++) begin
        acc_in <= ST_TAB[i][107:68];
        store_shift <= ST_TAB[i][67:64];
        cyc(2);
        check(store_out, k[0] ? ST_TAB[i][63:32] : ST_TAB[i][31:0]);
      end
    end
    // second hardware reset reloads the pointer and resamples the pin
    set_reg(16'h007F);
    hw_reset();
    axi_rd(PMC_OFFSET, 32'h0000FF80, RESP_OKAY);
    print_verdict();
  end
endmodule : processor_mode_status_reg_test
